// [shared/tdmsw_cfg.svh]
// constants of the tdm connection memory switch
`ifndef TDMSW_CFG_SVH
`define TDMSW_CFG_SVH
`define TDMSW_STREAMS      16
`define TDMSW_CM_DEPTH     512
`define TDMSW_CM_W         12
`define TDMSW_BANKS        8
`define TDMSW_CLK_NS       100
`define TDMSW_FILL_TIME_NS 50000
`define TDMSW_FILL_CYC     (`TDMSW_FILL_TIME_NS / `TDMSW_CLK_NS)
`define TDMSW_FILL_LANES   ((`TDMSW_CM_DEPTH + `TDMSW_FILL_CYC - 1) / `TDMSW_FILL_CYC)
`define TDMSW_CM_PAGE      3'h0
`define TDMSW_CTRL_ADDR    12'h200
`define TDMSW_IMS_ADDR     12'h201
`define TDMSW_STREAM_INPUT_DELAY_REGISTER_PAGE    8'h21
`define TDMSW_STREAM_OUTPUT_OFFSET_REGISTER_PAGE    8'h22
`define TDMSW_RATE_PAGE    8'h23
`define TDMSW_BPE_BIT      0
`define TDMSW_START_BIT    0
`define TDMSW_FILL_LSB     1
`define TDMSW_STREAM_INPUT_DELAY_REGISTER_CD_LSB  3
`define TDMSW_STREAM_OUTPUT_OFFSET_REGISTER_CD_LSB  5
`define TDMSW_ENT_MODE_BIT 0
`define TDMSW_ENT_CH_LSB   1
`define TDMSW_ENT_ST_LSB   8
`define TDMSW_ENT_MSG_LSB  3
`define TDMSW_CTL_MSG      2'h1
`define TDMSW_CTL_BER      2'h2
`define TDMSW_IDLE_BYTE    8'hff
`define TDMSW_IN_DLY_FRM   3'h2
`endif

// [shared/tdmsw_pkg.sv]
// types of the tdm connection memory switch
`include "tdmsw_cfg.svh"
package tdmsw_pkg;
    localparam int NS      = `TDMSW_STREAMS;
    localparam int DEPTH   = `TDMSW_CM_DEPTH;
    localparam int LANES   = `TDMSW_FILL_LANES;
    localparam int STEPS   = DEPTH / LANES;
    localparam int FIW     = $clog2(STEPS);
    localparam int BANKS   = `TDMSW_BANKS;
    localparam int BW      = $clog2(BANKS);
    typedef logic [11:0]             tdmsw_addr_t;
    typedef logic [15:0]             tdmsw_word_t;
    typedef logic [8:0]              tdmsw_idx_t;
    typedef logic [`TDMSW_CM_W-1:0]  tdmsw_ent_t;
    typedef logic [FIW-1:0]          tdmsw_fidx_t;
    typedef logic [NS-1:0]           tdmsw_mask_t;
    typedef logic [NS-1:0][7:0]      tdmsw_bytes_t;
    typedef tdmsw_idx_t [NS-1:0]     tdmsw_idxv_t;
    typedef tdmsw_ent_t [NS-1:0]     tdmsw_entv_t;
    typedef enum logic {TDMSW_FILL_IDLE, TDMSW_FILL_RUN} tdmsw_fill_t;
    typedef struct packed {
        logic [BANKS-1:0][DEPTH-1:0][7:0] dmem;
        logic [NS-1:0][9:0]               stream_input_delay_register;
        logic [NS-1:0][11:0]              stream_output_offset_register;
        logic [NS-1:0][1:0]               rate;
        logic                             bpe;
        logic                             start;
        logic [2:0]                       fill_bits;
        tdmsw_fill_t                      fsm;
        tdmsw_fidx_t                      fill_idx;
        logic [6:0]                       slot;
        logic [BW-1:0]                    frame;
        tdmsw_word_t                      rd_data;
        tdmsw_bytes_t                     out_bytes;
        tdmsw_mask_t                      out_hiz;
        tdmsw_mask_t                      out_bert;
        tdmsw_mask_t                      out_stb;
        logic                             busy;
    } tdmsw_state_t;
    typedef struct packed {
        tdmsw_ent_t [DEPTH-1:0] ent;
    } tdmsw_cm_state_t;
endpackage

// [shared/tdmsw_cm_if.sv]
// link between switch core and connection memory
`timescale 1ns/100ps
`default_nettype none
interface tdmsw_cm_if;
    import tdmsw_pkg::*;
    logic        host_we;
    tdmsw_idx_t  host_idx;
    tdmsw_ent_t  host_wdata;
    tdmsw_ent_t  host_rdata;
    logic        fill_we;
    tdmsw_fidx_t fill_idx;
    logic [2:0]  fill_bits;
    tdmsw_idxv_t rd_idx;
    tdmsw_entv_t rd_ent;
    modport ctl (output host_we, host_idx, host_wdata, fill_we, fill_idx,
                 fill_bits, rd_idx, input host_rdata, rd_ent);
    modport mem (input host_we, host_idx, host_wdata, fill_we, fill_idx,
                 fill_bits, rd_idx, output host_rdata, rd_ent);
endinterface
`default_nettype wire

// [verilog/tdmsw_cm.sv]
// connection memory: 512 entries, host port, fill port, stream reads
`timescale 1ns/100ps
`default_nettype none
module tdmsw_cm (
    input  wire logic sys_clk,
    input  wire logic nrst,
    tdmsw_cm_if.mem   bus
);
    import tdmsw_pkg::*;
    tdmsw_cm_state_t st_reg;
    tdmsw_cm_state_t st_next;
    tdmsw_ent_t [DEPTH-1:0] ent_w;

    genvar e;
    generate
        for (e = 0; e < DEPTH; e = e + 1) begin : g_ent
            // fill writes LANES neighbours per cycle, zeros above bit 2
            always_comb begin
                if (bus.fill_we && (FIW'(e / LANES) == bus.fill_idx)) begin
                    ent_w[e] = {9'h000, bus.fill_bits};
                end else if (bus.host_we && bus.host_idx == 9'(e)) begin
                    ent_w[e] = bus.host_wdata;
                end else begin
                    ent_w[e] = st_reg.ent[e];
                end
            end
        end
        for (e = 0; e < NS; e = e + 1) begin : g_rd
            assign bus.rd_ent[e] = st_reg.ent[bus.rd_idx[e]];
        end
    endgenerate

    assign bus.host_rdata = st_reg.ent[bus.host_idx];

    always_comb begin
        st_next.ent = ent_w;
        if (!nrst) begin
            st_next = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_reg <= st_next;
    end
endmodule
`default_nettype wire

// [verilog/tdmsw_top.sv]
// time-slot switch core with connection memory and block fill
//
// Summary of operation
// - nonzero input channel delay adds a frame buffer stage to the path
// - bit delay and fractional offsets never change throughput delay
// - input channels and delays span 32, 64 or 128 by rate
// - output channels and delays span 32, 64 or 128 by rate
// - no delays: two frames plus channel difference
// - input delay only: three frames minus input delay plus difference
// - output delay only: two frames plus output delay plus difference
// - both delays: three frames minus input plus output delay plus difference
// - connection memory holds 512 twelve-bit entries, one per output
// - bit 0 low: entry names source stream and channel to switch
// - bit 0 high: bits 1-2 pick high-impedance, message or test
// - message mode sends entry bits 3-10 as the channel byte
// - fill copies three fill bits into bits 0-2, zeros above
// - whole fill finishes within 50 microseconds
// - device clears start bit when fill is finished
// - clearing start or enable aborts a running fill
// - input channel delay comes from stream input delay bits 3-9
// - output channel delay comes from output offset bits 5-11
// - a frame carries 32, 64 or 128 output channels by rate
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tdmsw_top (
    input  wire logic               SYS_CLK,
    input  wire logic               NRST,
    input  wire tdmsw_pkg::tdmsw_addr_t  ADDR,
    input  wire tdmsw_pkg::tdmsw_word_t  WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output var  tdmsw_pkg::tdmsw_word_t  RDATA,
    input  wire logic               SLOT_TICK,
    input  wire logic               FRAME_START,
    input  wire tdmsw_pkg::tdmsw_bytes_t IN_BYTES,
    output var  tdmsw_pkg::tdmsw_bytes_t OUT_BYTES,
    output var  tdmsw_pkg::tdmsw_mask_t  OUT_HIZ,
    output var  tdmsw_pkg::tdmsw_mask_t  OUT_BERT,
    output var  tdmsw_pkg::tdmsw_mask_t  OUT_STB,
    output var  logic               FILL_BUSY
);
    import tdmsw_pkg::*;

    tdmsw_state_t st_reg;
    tdmsw_state_t st_next;
    tdmsw_cm_if   cm ();

    tdmsw_cm u_cm (
        .sys_clk (SYS_CLK),
        .nrst    (NRST),
        .bus     (cm)
    );

    // slot and frame seen by this tick
    logic [6:0]    cur_slot;
    logic [BW-1:0] cur_frame;
    logic          fill_run;
    logic          cm_sel;

    assign cur_slot  = FRAME_START ? 7'h00 : 7'(st_reg.slot + 7'h01);
    assign cur_frame = FRAME_START ? BW'(st_reg.frame + 1'b1) : st_reg.frame;
    assign fill_run  = st_reg.bpe && st_reg.start;
    assign cm_sel    = (ADDR[11:9] == `TDMSW_CM_PAGE);

    // host and fill sides of the connection memory
    assign cm.host_we    = WR && cm_sel
                           && (st_reg.fsm == TDMSW_FILL_IDLE);
    assign cm.host_idx   = ADDR[8:0];
    assign cm.host_wdata = WDATA[11:0];
    assign cm.fill_we    = (st_reg.fsm == TDMSW_FILL_RUN) && fill_run;
    assign cm.fill_idx   = st_reg.fill_idx;
    assign cm.fill_bits  = st_reg.fill_bits;

    // per stream switching terms
    logic [NS-1:0]         act_w;
    tdmsw_idx_t [NS-1:0]   widx_w;
    logic [NS-1:0][BW-1:0] wbank_w;
    tdmsw_bytes_t          obyte_w;
    tdmsw_mask_t           ohiz_w;
    tdmsw_mask_t           obert_w;

    genvar k;
    generate
        for (k = 0; k < NS; k = k + 1) begin : g_str
            logic [1:0]    rt;
            logic [6:0]    msk;
            logic [6:0]    pos;
            logic [6:0]    adly;
            logic [6:0]    bdly;
            logic [6:0]    in_ch;
            logic [6:0]    out_ch;
            logic [BW-1:0] rframe;
            logic [BW-1:0] rbank;
            tdmsw_ent_t    ent;
            logic [3:0]    src_st;
            logic [6:0]    src_ch;
            logic          src_dly;
            logic [7:0]    dbyte;

            assign rt  = st_reg.rate[k];
            // channels per frame: 32, 64 or 128
            assign msk = {rt[1], rt[1] | rt[0], 5'h1f};
            always_comb begin
                if (rt[1]) begin
                    act_w[k] = SLOT_TICK;
                    pos      = cur_slot;
                end else if (rt[0]) begin
                    act_w[k] = SLOT_TICK && !cur_slot[0];
                    pos      = {1'b0, cur_slot[6:1]};
                end else begin
                    act_w[k] = SLOT_TICK && (cur_slot[1:0] == 2'h0);
                    pos      = {2'h0, cur_slot[6:2]};
                end
            end
            // channel delays; bit delay fields never enter the timing
            assign adly = st_reg.stream_input_delay_register[k][`TDMSW_STREAM_INPUT_DELAY_REGISTER_CD_LSB +: 7] & msk;
            assign bdly = st_reg.stream_output_offset_register[k][`TDMSW_STREAM_OUTPUT_OFFSET_REGISTER_CD_LSB +: 7] & msk;
            assign in_ch  = 7'(pos - adly) & msk;
            assign out_ch = 7'(pos - bdly) & msk;
            // slots before the delay belong to the previous frame
            assign wbank_w[k] = BW'(cur_frame - BW'(pos < adly));
            assign rframe     = BW'(cur_frame - BW'(pos < bdly));
            assign widx_w[k]  = 9'({k[3:0], 5'h00} + {2'h0, in_ch});
            assign cm.rd_idx[k] = 9'({k[3:0], 5'h00} + {2'h0, out_ch});

            assign ent     = cm.rd_ent[k];
            assign src_st  = ent[`TDMSW_ENT_ST_LSB +: 4];
            assign src_ch  = ent[`TDMSW_ENT_CH_LSB +: 7];
            assign src_dly = |st_reg.stream_input_delay_register[src_st][`TDMSW_STREAM_INPUT_DELAY_REGISTER_CD_LSB +: 7];
            // two frames back, or three when the source is delayed
            assign rbank = BW'(rframe - BW'(`TDMSW_IN_DLY_FRM)
                               - BW'(src_dly));
            assign dbyte = st_reg.dmem[rbank][9'({src_st, 5'h00}
                                               + {2'h0, src_ch})];

            always_comb begin
                ohiz_w[k]  = 1'b0;
                obert_w[k] = 1'b0;
                if (!ent[`TDMSW_ENT_MODE_BIT]) begin
                    obyte_w[k] = dbyte;
                end else begin
                    case (ent[2:1])
                        `TDMSW_CTL_MSG: begin
                            obyte_w[k] = ent[`TDMSW_ENT_MSG_LSB +: 8];
                        end
                        `TDMSW_CTL_BER: begin
                            obyte_w[k] = `TDMSW_IDLE_BYTE;
                            obert_w[k] = 1'b1;
                        end
                        default: begin
                            obyte_w[k] = `TDMSW_IDLE_BYTE;
                            ohiz_w[k]  = 1'b1;
                        end
                    endcase
                end
            end
        end
    endgenerate

    always_comb begin
        st_next         = st_reg;
        st_next.out_stb = '0;
        st_next.rd_data = '0;

        // block fill engine, LANES entries per cycle
        case (st_reg.fsm)
            TDMSW_FILL_IDLE: begin
                st_next.fill_idx = '0;
                if (fill_run) begin
                    st_next.fsm = TDMSW_FILL_RUN;
                end
            end
            TDMSW_FILL_RUN: begin
                if (!fill_run) begin
                    st_next.fsm = TDMSW_FILL_IDLE;
                end else if (st_reg.fill_idx == FIW'(STEPS - 1)) begin
                    st_next.fsm   = TDMSW_FILL_IDLE;
                    st_next.start = 1'b0;
                end else begin
                    st_next.fill_idx = FIW'(st_reg.fill_idx + 1'b1);
                end
            end
            default: begin
                st_next.fsm = TDMSW_FILL_IDLE;
            end
        endcase
        st_next.busy = (st_next.fsm == TDMSW_FILL_RUN);

        // register writes; a host write of start overrides the self-clear
        if (WR) begin
            if (ADDR == `TDMSW_CTRL_ADDR) begin
                st_next.bpe = WDATA[`TDMSW_BPE_BIT];
            end else if (ADDR == `TDMSW_IMS_ADDR) begin
                st_next.start     = WDATA[`TDMSW_START_BIT];
                st_next.fill_bits = WDATA[`TDMSW_FILL_LSB +: 3];
            end else if (ADDR[11:4] == `TDMSW_STREAM_INPUT_DELAY_REGISTER_PAGE) begin
                st_next.stream_input_delay_register[ADDR[3:0]] = WDATA[9:0];
            end else if (ADDR[11:4] == `TDMSW_STREAM_OUTPUT_OFFSET_REGISTER_PAGE) begin
                st_next.stream_output_offset_register[ADDR[3:0]] = WDATA[11:0];
            end else if (ADDR[11:4] == `TDMSW_RATE_PAGE) begin
                st_next.rate[ADDR[3:0]] = WDATA[1:0];
            end
        end

        // register reads, answered in the next cycle
        if (RD) begin
            if (cm_sel) begin
                st_next.rd_data = {4'h0, cm.host_rdata};
            end else if (ADDR == `TDMSW_CTRL_ADDR) begin
                st_next.rd_data = {15'h0000, st_reg.bpe};
            end else if (ADDR == `TDMSW_IMS_ADDR) begin
                st_next.rd_data = {12'h000, st_reg.fill_bits, st_reg.start};
            end else if (ADDR[11:4] == `TDMSW_STREAM_INPUT_DELAY_REGISTER_PAGE) begin
                st_next.rd_data = {6'h00, st_reg.stream_input_delay_register[ADDR[3:0]]};
            end else if (ADDR[11:4] == `TDMSW_STREAM_OUTPUT_OFFSET_REGISTER_PAGE) begin
                st_next.rd_data = {4'h0, st_reg.stream_output_offset_register[ADDR[3:0]]};
            end else if (ADDR[11:4] == `TDMSW_RATE_PAGE) begin
                st_next.rd_data = {14'h0000, st_reg.rate[ADDR[3:0]]};
            end
        end

        // slot processing: store inputs, emit outputs
        if (SLOT_TICK) begin
            st_next.slot  = cur_slot;
            st_next.frame = cur_frame;
            for (int s = 0; s < NS; s++) begin
                if (act_w[s]) begin
                    st_next.dmem[wbank_w[s]][widx_w[s]] = IN_BYTES[s];
                    st_next.out_bytes[s] = obyte_w[s];
                    st_next.out_hiz[s]   = ohiz_w[s];
                    st_next.out_bert[s]  = obert_w[s];
                    st_next.out_stb[s]   = 1'b1;
                end
            end
        end

        if (!NRST) begin
            st_next         = '0;
            st_next.out_hiz = '1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        st_reg <= st_next;
    end

    assign RDATA     = st_reg.rd_data;
    assign OUT_BYTES = st_reg.out_bytes;
    assign OUT_HIZ   = st_reg.out_hiz;
    assign OUT_BERT  = st_reg.out_bert;
    assign OUT_STB   = st_reg.out_stb;
    assign FILL_BUSY = st_reg.busy;
endmodule
`default_nettype wire

// [bench/tdmsw_tdm_src.sv]
// serial stream timing and input byte source for the switch core
`timescale 1ns/100ps
`default_nettype none
module tdmsw_tdm_src (
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire logic                   run,
    output logic                        slot_tick,
    output logic                        frame_start,
    output logic [6:0]                  slot,
    output logic [3:0]                  frame,
    output tdmsw_pkg::tdmsw_bytes_t     in_bytes
);
    import tdmsw_pkg::*;
    logic [1:0] ph;
    logic [6:0] nslot;
    assign nslot = slot + 7'h01;
    // a slot tick every four clocks, 128 slots a frame
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            {ph, slot, frame, slot_tick, frame_start} <= '0;
        end else begin
            ph <= ph + 2'h1;
            slot_tick <= run && (ph == 2'h3);
            frame_start <= run && (ph == 2'h3) && (nslot == 7'h00);
            if (run && (ph == 2'h3)) begin
                slot <= nslot;
                if (nslot == 7'h00) frame <= frame + 4'h1;
            end
        end
    end
    // bytes carry frame tag and stream number; inverted off the tick
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            in_bytes[s] = slot_tick ? {frame, 4'(s)} : ~{frame, 4'(s)};
        end
    end
endmodule
`default_nettype wire

// [bench/tdmsw_top_chk.sv]
// port assertions of the switch core
`timescale 1ns/100ps
`default_nettype none
module tdmsw_top_chk (
    input  wire logic                   SYS_CLK,
    input  wire logic                   NRST,
    input  wire tdmsw_pkg::tdmsw_addr_t ADDR,
    input  wire tdmsw_pkg::tdmsw_word_t WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    input  wire tdmsw_pkg::tdmsw_word_t RDATA,
    input  wire logic                   SLOT_TICK,
    input  wire tdmsw_pkg::tdmsw_bytes_t OUT_BYTES,
    input  wire tdmsw_pkg::tdmsw_mask_t OUT_HIZ,
    input  wire tdmsw_pkg::tdmsw_mask_t OUT_BERT,
    input  wire tdmsw_pkg::tdmsw_mask_t OUT_STB,
    input  wire logic                   FILL_BUSY
);
    import tdmsw_pkg::*;
    logic [9:0]  busy_cnt;
    tdmsw_mask_t ff_mask;
    logic        start_wr;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    assign start_wr = WR && (ADDR == 12'h201) && WDATA[0];
    always_comb begin
        for (int i = 0; i < NS; i++) ff_mask[i] = (OUT_BYTES[i] == 8'hff);
    end
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) busy_cnt <= 10'h000;
        else busy_cnt <= FILL_BUSY ? busy_cnt + 10'h001 : 10'h000;
    end
    a_stb_from_tick: assert property (
        OUT_STB != 16'h0000 |-> $past(SLOT_TICK))
        else $error("strobe without tick");
    a_stb_single: assert property (
        OUT_STB != 16'h0000 |=> OUT_STB == 16'h0000)
        else $error("strobe too long");
    a_hold_out: assert property (
        OUT_STB == 16'h0000 |-> $stable(OUT_BYTES) && $stable(OUT_HIZ))
        else $error("output changed without strobe");
    a_bert_byte: assert property (
        (OUT_BERT & ~ff_mask) == 16'h0000)
        else $error("test channel byte not ff");
    a_mode_excl: assert property (
        (OUT_BERT & OUT_HIZ) == 16'h0000) else $error("test and hiz together");
    a_cm_rd_high: assert property (
        $past(RD) && $past(ADDR) < 12'h200 |-> RDATA[15:12] == 4'h0)
        else $error("entry read upper bits set");
    a_fill_bound: assert property (
        busy_cnt <= 10'h1f4) else $error("fill longer than 500 cycles");
    a_start_abort: assert property (
        WR && ADDR == 12'h201 && !WDATA[0] |-> ##2 !FILL_BUSY)
        else $error("fill not stopped by start clear");
    a_enable_abort: assert property (
        WR && ADDR == 12'h200 && !WDATA[0] |-> ##2 !FILL_BUSY)
        else $error("fill not stopped by enable clear");
    // the engine starts one cycle after start lands, and busy rises on that same edge
    a_busy_cause: assert property (
        $rose(FILL_BUSY) |-> $past(start_wr, 2))
        else $error("fill began unasked");
endmodule
bind tdmsw_top tdmsw_top_chk u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SLOT_TICK(SLOT_TICK), .OUT_BYTES(OUT_BYTES), .OUT_HIZ(OUT_HIZ),
    .OUT_BERT(OUT_BERT), .OUT_STB(OUT_STB), .FILL_BUSY(FILL_BUSY));
`default_nettype wire

// [bench/tdmsw_top_bench.sv]
// self-checking bench of the switch core
`timescale 1ns/100ps
`default_nettype none
module tdmsw_top_bench;
    import tdmsw_pkg::*;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_fail++; $display("ERROR %s expected %h seen %h", n, e, g); end end
    logic         sys_clk, nrst, wr_s, rd_s, tick, fstart;
    tdmsw_addr_t  addr;
    tdmsw_word_t  wdata, rdata;
    tdmsw_bytes_t in_b, out_b;
    tdmsw_mask_t  hiz, bert, stb;
    logic         busy;
    logic [6:0]   src_slot;
    logic [3:0]   src_frame;
    int           n_fail, comparisons;
    tdmsw_top dut (.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .SLOT_TICK(tick),
        .FRAME_START(fstart), .IN_BYTES(in_b), .OUT_BYTES(out_b),
        .OUT_HIZ(hiz), .OUT_BERT(bert), .OUT_STB(stb), .FILL_BUSY(busy));
    tdmsw_tdm_src src (.sys_clk(sys_clk), .nrst(nrst), .run(1'b1),
        .slot_tick(tick), .frame_start(fstart), .slot(src_slot),
        .frame(src_frame), .in_bytes(in_b));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input tdmsw_addr_t a, input tdmsw_word_t d);
        @(posedge sys_clk);
        addr <= a; wdata <= d; wr_s <= 1'b1;
        @(posedge sys_clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input tdmsw_addr_t a, input tdmsw_word_t e);
        @(posedge sys_clk);
        addr <= a; rd_s <= 1'b1;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask
    task automatic wait_slot(input logic [6:0] s, input int st);
        int k;
        k = 0;
        @(posedge sys_clk); #1;
        while (!(stb[st] === 1'b1 && src_slot === s) && k < 4000) begin
            @(posedge sys_clk); #1; k++;
        end
        `CHK("slot_seen", 1'b1, k < 4000)
    endtask
    task automatic t_fill();
        int n;
        n = 0;
        wr(12'h201, 16'h000a);
        rd(12'h201, 16'h000a);
        wr(12'h200, 16'h0001);
        wr(12'h201, 16'h000b);
        @(posedge sys_clk);
        #1 `CHK("fill_busy", 1'b1, busy)
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK("fill_time", 1'b1, n > 0 && n <= 500)
        rd(12'h201, 16'h000a);
        rd(12'h000, 16'h0005);
        rd(12'h1ff, 16'h0005);
        wr(12'h200, 16'h0000);
    endtask
    task automatic t_abort();
        wr(12'h201, 16'h0006);
        wr(12'h200, 16'h0001);
        wr(12'h201, 16'h0007);
        wr(12'h1ff, 16'h0123);
        wr(12'h201, 16'h0006);
        // the engine sees the cleared start one edge later
        @(posedge sys_clk);
        #1 `CHK("busy_abort", 1'b0, busy)
        rd(12'h000, 16'h0003);
        rd(12'h1ff, 16'h0005);
        wr(12'h201, 16'h0007);
        wr(12'h200, 16'h0000);
        @(posedge sys_clk);
        #1 `CHK("busy_abort_en", 1'b0, busy)
        wr(12'h201, 16'h0000);
    endtask
    task automatic t_modes();
        wr(12'h005, 16'h052b);
        wr(12'h025, 16'h0005);
        wr(12'h045, 16'h0001);
        rd(12'h005, 16'h052b);
        wait_slot(7'h14, 0);
        `CHK("msg_byte", 8'ha5, out_b[0])
        `CHK("msg_hiz", 1'b0, hiz[0])
        `CHK("ber_flag", 1'b1, bert[1])
        `CHK("hiz_flag", 1'b1, hiz[2])
    endtask
    // stream 8 channel 2 switched to stream 0 channel 7 at rate r;
    // bf goes into the bit delay and fractional fields
    task automatic t_delay(input logic [1:0] r, input logic [6:0] a,
                           input logic [6:0] b, input logic [4:0] bf);
        logic [3:0] tag;
        logic [6:0] p;
        wr(12'h230, 16'(r));
        wr(12'h238, 16'(r));
        wr(12'h218, {6'h00, a, bf[2:0]});
        wr(12'h220, {4'h0, b, bf});
        wr(12'h007, 16'h0804);
        rd(12'h218, {6'h00, a, bf[2:0]});
        rd(12'h220, {4'h0, b, bf});
        repeat (2048) @(posedge sys_clk);
        p = 7'(b + 7'h07);
        case (r)
            2'h0: wait_slot({p[4:0], 2'h0}, 0);
            2'h1: wait_slot({p[5:0], 1'b0}, 0);
            default: wait_slot(p, 0);
        endcase
        tag = src_frame - 4'h2 - {3'h0, a != 7'h00};
        `CHK("switched", {tag, 4'h8}, out_b[0])
    endtask
    initial begin
        #3_000_000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        {nrst, wr_s, rd_s, addr, wdata} = '0;
        n_fail = 0;
        comparisons = 0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        #1 `CHK("hiz_reset", 16'hffff, hiz)
        `CHK("busy_reset", 1'b0, busy)
        rd(12'h3ff, 16'h0000);
        t_fill();
        t_abort();
        t_modes();
        t_delay(2'h0, 7'h00, 7'h00, 5'h00);
        t_delay(2'h0, 7'h05, 7'h00, 5'h00);
        t_delay(2'h0, 7'h00, 7'h03, 5'h00);
        t_delay(2'h0, 7'h05, 7'h03, 5'h1d);
        t_delay(2'h1, 7'h25, 7'h30, 5'h00);
        t_delay(2'h2, 7'h45, 7'h70, 5'h0a);
        report_and_stop();
    end
endmodule
`default_nettype wire
